/* File: verilog/dzc_regs.vh */
`ifndef DZC_REGS_VH
`define DZC_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define DZC_OFF_CTRL        8'h00
`define DZC_OFF_FILT        8'h04
`define DZC_OFF_DEMAG_TIME  8'h08
`define DZC_OFF_ZERO_TIME   8'h0C
`define DZC_OFF_STATUS      8'h10
`define DZC_OFF_MASK        8'h14
`define DZC_OFF_PHASE       8'h18

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define DZC_CTRL_HDM        0
`define DZC_CTRL_SDM        1
`define DZC_CTRL_HZ         2
`define DZC_CTRL_SZ         3
`define DZC_CTRL_CPB        4
`define DZC_CTRL_ZVD        5
`define DZC_CTRL_REO        6
`define DZC_CTRL_PZ         7
`define DZC_CTRL_SENSOR     8
`define DZC_CTRL_DIRECT     9
`define DZC_CTRL_OS_LO      12
`define DZC_CTRL_W          15

// ------------------------------------------------------------
// filter register fields, filter and control reset values
// ------------------------------------------------------------
`define DZC_FILT_ZEF_LO     0
`define DZC_FILT_DEF_LO     4
`define DZC_FILT_ZWF_LO     8
`define DZC_FILT_RST        12'hF00
`define DZC_CTRL_RST        15'h0000

// ------------------------------------------------------------
// status bits and bus answers
// ------------------------------------------------------------
`define DZC_ST_DEMAG        0
`define DZC_ST_ZERO         1
`define DZC_RESP_OKAY       2'h0
`define DZC_RESP_SLVERR     2'h2

// ------------------------------------------------------------
// blanking window timing: 5 us steps up to 40 us, then 20 us steps
// ------------------------------------------------------------
`define DZC_CLK_MHZ         250
`define DZC_WIN_STEP_NS     5000
`define DZC_WIN_WIDE_NS     20000
`define DZC_WIN_KNEE        4'h7

`endif

/* File: verilog/dzc_filter.v */
`timescale 1ns/1ps

// consecutive-sample filter: pulses once when limit samples in a row match
module dzc_filter #(
    parameter CW = 4
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          srst_i,
    // control
    input  wire          clear_i,
    input  wire          arm_i,
    input  wire          sample_i,
    input  wire          match_i,
    input  wire [CW-1:0] limit_m1_i,
    // result
    output reg           hit_o
);

    reg [CW:0] cnt_reg;

    // count matching samples, restart on a miss
    always @(posedge clk_i) begin
        if (srst_i || clear_i || !arm_i) begin
            cnt_reg <= {(CW+1){1'b0}};
            hit_o   <= 1'b0;
        end else if (sample_i) begin
            if (!match_i) begin
                cnt_reg <= {(CW+1){1'b0}};
                hit_o   <= 1'b0;
            end else if (cnt_reg == {1'b0, limit_m1_i}) begin
                cnt_reg <= {(CW+1){1'b0}};
                hit_o   <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + {{CW{1'b0}}, 1'b1};
                hit_o   <= 1'b0;
            end
        end else begin
            hit_o <= 1'b0;
        end
    end

endmodule // dzc_filter

/* File: verilog/dzc_events.v */
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ps
`include "dzc_regs.vh"

module dzc_events #(
    parameter TW = 16
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          srst_i,
    // axi4-lite write address
    input  wire [7:0]    s_axi_awaddr,
    input  wire          s_axi_awvalid,
    output reg           s_axi_awready,
    // axi4-lite write data
    input  wire [31:0]   s_axi_wdata,
    input  wire [3:0]    s_axi_wstrb,
    input  wire          s_axi_wvalid,
    output reg           s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]    s_axi_bresp,
    output reg           s_axi_bvalid,
    input  wire          s_axi_bready,
    // axi4-lite read
    input  wire [7:0]    s_axi_araddr,
    input  wire          s_axi_arvalid,
    output reg           s_axi_arready,
    output reg  [31:0]   s_axi_rdata,
    output reg  [1:0]    s_axi_rresp,
    output reg           s_axi_rvalid,
    input  wire          s_axi_rready,
    // motor side
    input  wire          phase_cmp_i,
    input  wire          sample_i,
    input  wire          commutation_i,
    input  wire          pwm_high_i,
    input  wire [TW-1:0] step_timer_i,
    // events out
    output reg           demag_event_o,
    output reg           zero_event_o,
    output reg           delay_mgr_zero_o,
    output reg  [2:0]    output_group_select_o,
    output reg           irq_o
);

    // ------------------------------------------------------------
    // timing constants
    // ------------------------------------------------------------
    localparam [15:0] STEP_CYC = (`DZC_WIN_STEP_NS * `DZC_CLK_MHZ) / 1000;
    localparam [15:0] WIDE_CYC = (`DZC_WIN_WIDE_NS * `DZC_CLK_MHZ) / 1000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [`DZC_CTRL_W-1:0] ctrl_shadow_reg;
    reg [`DZC_CTRL_W-1:0] ctrl_reg;
    reg [11:0]            filt_shadow_reg;
    reg [11:0]            filt_reg;
    reg [TW-1:0]          demag_time_reg;
    reg [TW-1:0]          zero_cross_time_reg;
    reg [1:0]             motor_irq_status;
    reg [1:0]             motor_irq_mask;
    reg [7:0]             phase_state_reg;
    reg [7:0]             aw_reg;
    reg [31:0]            wd_reg;
    reg [3:0]             ws_reg;
    reg                   aw_ok;
    reg                   w_ok;

    // synchronised comparator and sample strobe
    reg [1:0] cmp_sync;
    reg [1:0] smp_sync;
    reg       smp_d;
    reg       cmp_prev;

    // step sequencing
    reg        demag_done;
    reg        zero_done;
    reg        c_check;
    reg        d_check;
    reg [15:0] blank_cnt;

    wire hw_demag_enable   = ctrl_reg[`DZC_CTRL_HDM];
    wire sim_demag_enable  = ctrl_reg[`DZC_CTRL_SDM];
    wire hw_zero_capture_enable = ctrl_reg[`DZC_CTRL_HZ];
    wire sim_zero_enable   = ctrl_reg[`DZC_CTRL_SZ];
    wire comparator_edge_polarity = ctrl_reg[`DZC_CTRL_CPB];
    wire edge_relation_select = ctrl_reg[`DZC_CTRL_ZVD];
    wire sensing_group_select = ctrl_reg[`DZC_CTRL_REO];
    wire zero_protect_enable  = ctrl_reg[`DZC_CTRL_PZ];
    wire sensor_mode       = ctrl_reg[`DZC_CTRL_SENSOR];
    wire direct_mode       = ctrl_shadow_reg[`DZC_CTRL_DIRECT];
    wire [3:0] zero_sample_count = filt_reg[`DZC_FILT_ZEF_LO+3:`DZC_FILT_ZEF_LO];
    wire [3:0] demag_sample_count = filt_reg[`DZC_FILT_DEF_LO+3:`DZC_FILT_DEF_LO];
    wire [3:0] zero_blank_window  = filt_reg[`DZC_FILT_ZWF_LO+3:`DZC_FILT_ZWF_LO];
    wire smp_tick = smp_sync[1] & ~smp_d;
    wire cmp_now  = cmp_sync[1];

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            cmp_sync <= 2'h0;
            smp_sync <= 2'h0;
            smp_d    <= 1'b0;
            cmp_prev <= 1'b0;
        end else begin
            cmp_sync <= {cmp_sync[0], phase_cmp_i};
            smp_sync <= {smp_sync[0], sample_i};
            smp_d    <= smp_sync[1];
            if (smp_tick)
                cmp_prev <= cmp_sync[1];
        end
    end

    // demag expects comparator to reach cpb^~zvd; zero reaches cpb
    wire demag_level = comparator_edge_polarity ^ ~edge_relation_select;
    wire zero_level  = comparator_edge_polarity;
    wire on_sense_group = (pwm_high_i == sensing_group_select) | sensor_mode;

    // ------------------------------------------------------------
    // event conditions
    // ------------------------------------------------------------
    wire demag_arm  = ~demag_done & ~c_check & ~sensor_mode;
    wire blanked    = (blank_cnt != 16'h0000);
    wire zero_arm   = demag_done & ~zero_done & ~d_check;
    wire zh_match   = (cmp_now == zero_level) & on_sense_group &
                      (~zero_protect_enable | (cmp_prev != zero_level));
    wire [3:0] zero_limit_m1 = zero_protect_enable ? 4'h0 : zero_sample_count;
    wire sim_zero_only = sim_zero_enable & ~hw_zero_capture_enable;
    wire dh_hit;
    wire zh_hit;

    // demag sample filter
    dzc_filter #(.CW(4)) u_demag_filt (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .clear_i    (commutation_i),
        .arm_i      (demag_arm & hw_demag_enable),
        .sample_i   (smp_tick),
        .match_i    (cmp_now == demag_level),
        .limit_m1_i (demag_sample_count),
        .hit_o      (dh_hit)
    );

    // zero sample filter, hardware crossings only
    dzc_filter #(.CW(4)) u_zero_filt (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .clear_i    (commutation_i),
        .arm_i      (zero_arm & ~blanked & ~sim_zero_only),
        .sample_i   (smp_tick),
        .match_i    (zh_match),
        .limit_m1_i (zero_limit_m1),
        .hit_o      (zh_hit)
    );

    wire dh_evt = dh_hit & demag_arm;
    wire ds_evt = sim_demag_enable & demag_arm &
                  (c_check ? 1'b0 : (step_timer_i == demag_time_reg));
    wire ds_now = sim_demag_enable & c_check & (demag_time_reg <= step_timer_i);
    wire d_evt  = dh_evt | ds_evt | ds_now | (c_check & ~sim_demag_enable & sensor_mode);
    wire zh_evt = zh_hit & zero_arm & ~blanked;
    wire zs_evt = sim_zero_enable & zero_arm & (step_timer_i == zero_cross_time_reg);
    wire zs_now = sim_zero_enable & d_check & (zero_cross_time_reg <= step_timer_i);
    wire z_evt  = zh_evt | zs_evt | zs_now;

    // ------------------------------------------------------------
    // step sequencing, blanking window and event outputs
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            demag_done       <= 1'b0;
            zero_done        <= 1'b0;
            c_check          <= 1'b0;
            d_check          <= 1'b0;
            blank_cnt        <= 16'h0000;
            demag_event_o    <= 1'b0;
            zero_event_o     <= 1'b0;
            delay_mgr_zero_o <= 1'b0;
            output_group_select_o <= 3'h0;
        end else begin
            demag_event_o    <= d_evt & ~commutation_i;
            zero_event_o     <= z_evt & ~commutation_i;
            delay_mgr_zero_o <= z_evt & ~commutation_i;
            if (commutation_i) begin
                demag_done <= sensor_mode;
                zero_done  <= 1'b0;
                c_check    <= ~sensor_mode;
                d_check    <= 1'b0;
                blank_cnt  <= 16'h0000;
                output_group_select_o <= 3'h0;
            end else begin
                c_check <= 1'b0;
                d_check <= 1'b0;
                if (blanked)
                    blank_cnt <= blank_cnt - 16'h0001;
                if (d_evt) begin
                    demag_done <= 1'b1;
                    d_check    <= 1'b1;
                    if (!sensor_mode)
                        blank_cnt <= (zero_blank_window <= `DZC_WIN_KNEE) ?
                            STEP_CYC * ({12'h000, zero_blank_window} + 16'h0001) :
                            STEP_CYC * ({12'h000, `DZC_WIN_KNEE} + 16'h0001) + WIDE_CYC *
                            ({12'h000, zero_blank_window} - {12'h000, `DZC_WIN_KNEE});
                    output_group_select_o <= ctrl_reg[`DZC_CTRL_OS_LO+2:`DZC_CTRL_OS_LO];
                end
                if (z_evt) begin
                    zero_done <= 1'b1;
                    output_group_select_o <= ~ctrl_reg[`DZC_CTRL_OS_LO+2:`DZC_CTRL_OS_LO];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // axi4-lite handshake
    // ------------------------------------------------------------
    wire wr_go = aw_ok & w_ok & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire [31:0] wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};
    wire wr_hit = (aw_reg == `DZC_OFF_CTRL) | (aw_reg == `DZC_OFF_FILT) |
                  (aw_reg == `DZC_OFF_DEMAG_TIME) | (aw_reg == `DZC_OFF_ZERO_TIME) |
                  (aw_reg == `DZC_OFF_STATUS) | (aw_reg == `DZC_OFF_MASK) |
                  (aw_reg == `DZC_OFF_PHASE);
    wire phase_wr = wr_go & (aw_reg == `DZC_OFF_PHASE);
    wire [31:0] wnew_ctrl = ({17'h00000, ctrl_shadow_reg} & ~wmask) | (wd_reg & wmask);
    wire [31:0] wnew_filt = ({20'h00000, filt_shadow_reg} & ~wmask) | (wd_reg & wmask);
    wire [31:0] wnew_dt = ({{(32-TW){1'b0}}, demag_time_reg} & ~wmask) | (wd_reg & wmask);
    wire [31:0] wnew_zt = ({{(32-TW){1'b0}}, zero_cross_time_reg} & ~wmask) |
                          (wd_reg & wmask);

    always @(posedge clk_i) begin
        if (srst_i) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DZC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `DZC_RESP_OKAY;
            s_axi_rdata   <= 32'h00000000;
            aw_ok  <= 1'b0;
            w_ok   <= 1'b0;
            aw_reg <= 8'h00;
            wd_reg <= 32'h00000000;
            ws_reg <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_ok & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_ok & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_ok  <= 1'b1;
                aw_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_ok   <= 1'b1;
                wd_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ok        <= 1'b0;
                w_ok         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `DZC_RESP_OKAY : `DZC_RESP_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `DZC_RESP_OKAY;
                case (s_axi_araddr)
                    `DZC_OFF_CTRL:       s_axi_rdata <= {17'h00000, ctrl_shadow_reg};
                    `DZC_OFF_FILT:       s_axi_rdata <= {20'h00000, filt_shadow_reg};
                    `DZC_OFF_DEMAG_TIME: s_axi_rdata <= {{(32-TW){1'b0}}, demag_time_reg};
                    `DZC_OFF_ZERO_TIME:  s_axi_rdata <= {{(32-TW){1'b0}}, zero_cross_time_reg};
                    `DZC_OFF_STATUS:     s_axi_rdata <= {30'h00000000, motor_irq_status};
                    `DZC_OFF_MASK:       s_axi_rdata <= {30'h00000000, motor_irq_mask};
                    `DZC_OFF_PHASE:      s_axi_rdata <= {24'h000000, phase_state_reg};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `DZC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // register file, captures and flags
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_shadow_reg     <= `DZC_CTRL_RST;
            ctrl_reg            <= `DZC_CTRL_RST;
            filt_shadow_reg     <= `DZC_FILT_RST;
            filt_reg            <= `DZC_FILT_RST;
            demag_time_reg      <= {TW{1'b0}};
            zero_cross_time_reg <= {TW{1'b0}};
            motor_irq_status    <= 2'h0;
            motor_irq_mask      <= 2'h0;
            phase_state_reg     <= 8'h00;
            irq_o               <= 1'b0;
        end else begin
            if (wr_go && aw_reg == `DZC_OFF_CTRL)
                ctrl_shadow_reg <= wnew_ctrl[`DZC_CTRL_W-1:0];
            if (wr_go && aw_reg == `DZC_OFF_FILT)
                filt_shadow_reg <= wnew_filt[11:0];
            if (wr_go && aw_reg == `DZC_OFF_MASK)
                motor_irq_mask <= wnew_ctrl[1:0] & wmask[1:0] | motor_irq_mask & ~wmask[1:0];
            if (phase_wr)
                phase_state_reg <= wd_reg[7:0];
            // preload transfer
            if ((commutation_i && !direct_mode) || (phase_wr && direct_mode)) begin
                ctrl_reg <= ctrl_shadow_reg;
                filt_reg <= filt_shadow_reg;
            end
            // timer registers: software write, then hardware capture wins
            if (wr_go && aw_reg == `DZC_OFF_DEMAG_TIME)
                demag_time_reg <= wnew_dt[TW-1:0];
            if (dh_evt && hw_demag_enable)
                demag_time_reg <= step_timer_i;
            else if (ds_now)
                demag_time_reg <= step_timer_i;
            if (wr_go && aw_reg == `DZC_OFF_ZERO_TIME)
                zero_cross_time_reg <= wnew_zt[TW-1:0];
            if (zh_evt && hw_zero_capture_enable)
                zero_cross_time_reg <= step_timer_i;
            else if (zs_now)
                zero_cross_time_reg <= step_timer_i;
            // write one to clear, event set wins
            motor_irq_status[`DZC_ST_DEMAG] <=
                (d_evt & ~commutation_i) |
                (motor_irq_status[`DZC_ST_DEMAG] &
                 ~(wr_go && aw_reg == `DZC_OFF_STATUS && ws_reg[0] && wd_reg[0]));
            motor_irq_status[`DZC_ST_ZERO] <=
                (z_evt & ~commutation_i) |
                (motor_irq_status[`DZC_ST_ZERO] &
                 ~(wr_go && aw_reg == `DZC_OFF_STATUS && ws_reg[0] && wd_reg[1]));
            irq_o <= |(motor_irq_status & motor_irq_mask);
        end
    end

endmodule // dzc_events

/* File: tb/dzc_motor_model.sv */
`timescale 1ns/1ps
// stand-in for comparator, sampler and step timer
module dzc_motor_model (
    input  wire        clk_i, srst_i, comm_req_i, level_i,
    output reg         phase_cmp_o, sample_o, commutation_o,
    output reg  [15:0] step_timer_o
);
    reg [2:0] div_reg;
    // ---------------------------------------------
    // sampler every 8 clocks, timer restarts at commutation
    // ---------------------------------------------
    always @(posedge clk_i) begin
        div_reg <= srst_i ? 3'h0 : div_reg + 3'h1;
        sample_o <= div_reg[2];
        commutation_o <= comm_req_i;
        phase_cmp_o <= level_i;
        step_timer_o <= (srst_i || comm_req_i) ? 16'h0000 : step_timer_o + 16'h0001;
    end
endmodule // dzc_motor_model

/* File: tb/dzc_events_asserts.sv */
`timescale 1ns/1ps
module dzc_events_asserts (
    input wire       clk_i, srst_i, commutation_i, s_axi_bready, s_axi_rready,
    input wire       demag_event_o, zero_event_o, delay_mgr_zero_o, s_axi_bvalid, s_axi_rvalid,
    input wire [2:0] output_group_select_o
);
    reg d_seen_reg, z_seen_reg;
    // events seen in this step, cleared at commutation
    always @(posedge clk_i) begin
        d_seen_reg <= !srst_i && !commutation_i && (d_seen_reg || demag_event_o);
        z_seen_reg <= !srst_i && !commutation_i && (z_seen_reg || zero_event_o);
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_one_demag: assert property (demag_event_o |-> !d_seen_reg)
        else $error("second demag in step");
    a_one_zero: assert property (zero_event_o |-> !z_seen_reg)
        else $error("second zero in step");
    a_zero_after_d: assert property (zero_event_o |-> d_seen_reg)
        else $error("zero before demag");
    a_zero_to_dm: assert property (delay_mgr_zero_o == zero_event_o)
        else $error("delay manager pulse wrong");
    a_group_at_c: assert property (commutation_i |=> output_group_select_o == 3'h0)
        else $error("group not cleared");
    a_demag_pulse: assert property (demag_event_o |=> !demag_event_o)
        else $error("demag not a pulse");
    a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid stuck");
endmodule // dzc_events_asserts
bind dzc_events dzc_events_asserts u_chk (.clk_i, .srst_i, .commutation_i, .s_axi_bready,
    .s_axi_rready, .demag_event_o, .zero_event_o, .delay_mgr_zero_o, .s_axi_bvalid,
    .s_axi_rvalid, .output_group_select_o);

/* File: tb/dzc_events_bench.sv */
`timescale 1ns/1ps
`include "dzc_regs.vh"
module dzc_events_bench;
    reg clk_i = 0, srst_i = 1, comm = 0, lvl = 0, pwm_high_i = 0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    reg [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0, rd;
    reg [1:0] rr;
    reg [15:0] t;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire phase_cmp_i, sample_i, commutation_i, demag_event_o, zero_event_o, irq_o;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] step_timer_i;
    wire [2:0] output_group_select_o;
    integer err_count = 0, n_compared = 0, n;
    dzc_events dut (.clk_i, .srst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .phase_cmp_i, .sample_i, .commutation_i, .pwm_high_i, .step_timer_i,
        .demag_event_o, .zero_event_o, .delay_mgr_zero_o(), .output_group_select_o, .irq_o);
    dzc_motor_model mdl (.clk_i, .srst_i, .comm_req_i(comm), .level_i(lvl),
        .phase_cmp_o(phase_cmp_i), .sample_o(sample_i), .commutation_o(commutation_i),
        .step_timer_o(step_timer_i));
    initial forever #2 clk_i = ~clk_i;
    initial begin
        #40000;
        err_count = err_count + 1;
        print_verdict;
    end
    task print_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [31:0] seen, exp, input [79:0] what);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR %0s exp %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        rr = s_axi_bresp;
    endtask
    task rd_reg(input [7:0] a);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    task cmt;
        @(posedge clk_i);
        comm <= 1;
        @(posedge clk_i);
        comm <= 0;
    endtask
    task wait_ev(input z);
        n = 0;
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (!(z ? zero_event_o : demag_event_o) && n < 3000);
        t = step_timer_i;
        chk(n < 3000, 1, "event");
    endtask
    task t_reset;
        rd_reg(`DZC_OFF_FILT);
        chk(rd, 32'h00000F00, "filt rst");
        rd_reg(8'h1C);
        chk(rr, `DZC_RESP_SLVERR, "unmapped");
        wr(8'h1C, 32'h0);
        chk(rr, `DZC_RESP_SLVERR, "wr unmap");
        $display("reset test done");
    endtask
    task t_sim_demag;
        wr(`DZC_OFF_MASK, 32'h3);
        wr(`DZC_OFF_DEMAG_TIME, 32'h28);
        wr(`DZC_OFF_CTRL, 32'h2);
        cmt;
        wait_ev(0);
        chk(t >= 16'h28 && t <= 16'h2A, 1, "sim demag");
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1, "irq");
        rd_reg(`DZC_OFF_STATUS);
        chk(rd, 32'h1, "status d");
        wr(`DZC_OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 0, "irq clr");
        $display("sim demag test done");
    endtask
    task t_stale;
        wr(`DZC_OFF_DEMAG_TIME, 32'h0);
        cmt;
        wait_ev(0);
        chk(n <= 5, 1, "stale fire");
        rd_reg(`DZC_OFF_DEMAG_TIME);
        chk(rd != 0 && rd <= 3, 1, "stale ovw");
        $display("stale demag test done");
    endtask
    task t_hw_demag;
        wr(`DZC_OFF_FILT, 32'h20);
        wr(`DZC_OFF_CTRL, 32'h1);
        cmt;
        repeat (50) @(posedge clk_i);
        lvl <= 1;
        wait_ev(0);
        chk(n >= 17 && n <= 32, 1, "hw count");
        rd_reg(`DZC_OFF_DEMAG_TIME);
        chk(t - rd <= 3, 1, "capture");
        $display("hw demag test done");
    endtask
    task t_zero;
        pwm_high_i <= 1;
        wr(`DZC_OFF_STATUS, 32'h3);
        wr(`DZC_OFF_ZERO_TIME, 32'h7D0);
        wr(`DZC_OFF_DEMAG_TIME, 32'h14);
        wr(`DZC_OFF_CTRL, 32'h504A);
        cmt;
        wait_ev(0);
        repeat (3) @(posedge clk_i);
        chk(output_group_select_o, 3'h5, "group d");
        wait_ev(1);
        chk(t >= 16'h7D0 && t <= 16'h7D2, 1, "sim zero");
        repeat (3) @(posedge clk_i);
        chk(output_group_select_o, 3'h2, "group z");
        rd_reg(`DZC_OFF_STATUS);
        chk(rd, 32'h3, "status z");
        $display("zero test done");
    endtask
    task t_hw_zero;
        lvl <= 0;
        wr(`DZC_OFF_FILT, 32'h1);
        wr(`DZC_OFF_DEMAG_TIME, 32'h14);
        wr(`DZC_OFF_CTRL, 32'h46);
        cmt;
        wait_ev(0);
        wait_ev(1);
        chk(t >= 16'h4F6 && t <= 16'h510, 1, "blank");
        rd_reg(`DZC_OFF_ZERO_TIME);
        chk(t - rd <= 3, 1, "zcapture");
        $display("hw zero test done");
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        srst_i <= 0;
        t_reset;
        t_sim_demag;
        t_stale;
        t_hw_demag;
        t_zero;
        t_hw_zero;
        print_verdict;
    end
endmodule // dzc_events_bench
